// ---- design/sar_adc_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the converter control
// Included by the package and the control module; definitions only
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

`define OFS_MODE        8'h00
`define OFS_START       8'h04
`define OFS_RES_HIGH    8'h08
`define OFS_RES_LOW     8'h0C
`define OFS_CLK_STOP    8'h10
`define OFS_IRQ_REQ     8'h14
`define OFS_IRQ_EN      8'h18
`define OFS_PORT_MODE   8'h1C
`define OFS_EDGE_SEL    8'h20

`define MODE_SPEED_BIT  7
`define MODE_TRIG_BIT   6
`define START_FLAG_BIT  7
`define STBY_BIT        4
`define IRQ_BIT         3
`define PIN_FUNC_BIT    4
`define EDGE_SEL_BIT    4

`define MODE_RESET      8'h30
`define START_RESET     8'h7F

`define PERIOD_SLOW     6'd62
`define PERIOD_FAST     6'd31
`define STEP_CYCLES     2'd3
`define APPROX_CYCLES   6'd30

`endif

// ---- design/sar_adc_control.sv ----
// Control of a 10-bit successive-approximation converter behind an AXI4-Lite slave
// Assumes an analog mux, DAC and comparator outside; comparator and trigger are asynchronous
//
// Operation
// [RULE1] Standby control bit 0 puts converter in standby; resets to 1, active.
// [RULE2] Conversion works by successive approximation, giving a 10-bit result.
// [RULE3] Writing start flag 1 begins conversion; flag reads 1 until hardware clears it.
// [RULE4] Flag falling at completion sets the conversion-end request flag.
// [RULE5] Conversion-end interrupt raised only while its enable bit is 1.
// [RULE6] Software clears start flag before changing speed or channel mid-conversion.
// [RULE7] Trigger pin starts only when pin function bit and trigger enable both 1.
// [RULE8] Selected trigger edge sets the start flag and starts a conversion.
// [RULE9] Reset initialises mode and start registers; result registers keep contents.
// [RULE10] Registers function in active and sleep; held in all low-power modes.
// [RULE11] Completion stores result, clears flag, sets request together, then idles.
// [RULE12] Channel select 0101 routes analog input one to the converter.
// [RULE13] Setting the flag again after completion runs the whole sequence again.
// [RULE14] Software reads results only while the start flag reads 0.
// [RULE15] Software waits 10 clocks after leaving standby before starting.
// [RULE16] Upper eight result bits in high register, lower two in low bits 7:6.
// [RULE17] Speed bit 0 gives 62 clock conversion, 1 gives 31 clocks.
// [RULE18] Writing 0 to the start flag during conversion stops it.
// [RULE19] Upper channel bits 00 select none; 01xx channels 0-3, 10xx channels 4-7.
// [RULE20] In standby, start requests are ignored and converter registers do not change.
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_cfg.svh"

module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              low_power_hold,
  input  wire logic              external_trigger_pin,
  input  wire logic              comparator_in,
  output logic [9:0]             dac_code,
  output logic [2:0]             analog_channel_sel,
  output logic                   analog_channel_valid,
  output logic                   sample_hold,
  output logic                   conversion_end_irq
);

  initial begin
    if (ADDR_W < 6 || ADDR_W > 32) begin
      $error("ADDR_W must lie between 6 and 32");
    end
  end

  // Channel decode; upper bits 00 or 11 select nothing
  function automatic logic [3:0] chan_decode(input logic [3:0] sel);
    logic [3:0] r;
    r = 4'h0;
    case (sel[3:2])
      2'b01:   r = {1'b1, 1'b0, sel[1:0]}; // [RULE19] [RULE12]
      2'b10:   r = {1'b1, 1'b1, sel[1:0]}; // [RULE19]
      default: r = 4'h0;                   // [RULE19]
    endcase
    return r;
  endfunction

  // Bus slave state
  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [7:0]        wbyte_q, wbyte_d;
  logic              wlane_q, wlane_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  axi_resp_t         bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;

  // Converter register state
  logic [7:0]  mode_q, mode_d;
  logic        flag_q, flag_d;
  logic        stby_q, stby_d;
  logic        req_q, req_d, ien_q, ien_d, pfun_q, pfun_d, edge_q, edge_d;
  conv_state_e st_q, st_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [1:0]  step_q, step_d;
  logic [3:0]  bit_q, bit_d;
  logic [9:0]  sar_q, sar_d;
  logic [9:0]  res_q, res_d;
  logic [2:0]  trig_sync_q, trig_sync_d;
  logic [1:0]  comp_sync_q, comp_sync_d;

  logic        wr_go, wr_en, ok_addr, run_ok, sw_start, sw_stop, trig_start, done;
  logic [5:0]  period, sample_len;
  logic [9:0]  sar_dec;
  logic        mapped_r;
  logic [7:0]  rbyte;
  logic [3:0]  chan_bits;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // Held in low-power modes and in module standby
  assign run_ok  = stby_q && !low_power_hold; // [RULE1] [RULE10] [RULE20]
  assign wr_go   = aw_have_q && w_have_q && !bvalid_q;
  assign wr_en   = wr_go && wlane_q;
  assign ok_addr = (waddr_q == ADDR_W'(`OFS_MODE)) || (waddr_q == ADDR_W'(`OFS_START))
                || (waddr_q == ADDR_W'(`OFS_RES_HIGH)) || (waddr_q == ADDR_W'(`OFS_RES_LOW))
                || (waddr_q == ADDR_W'(`OFS_CLK_STOP)) || (waddr_q == ADDR_W'(`OFS_IRQ_REQ))
                || (waddr_q == ADDR_W'(`OFS_IRQ_EN)) || (waddr_q == ADDR_W'(`OFS_PORT_MODE))
                || (waddr_q == ADDR_W'(`OFS_EDGE_SEL));

  assign sw_start = run_ok && wr_en && (waddr_q == ADDR_W'(`OFS_START))
                 && wbyte_q[`START_FLAG_BIT] && !flag_q; // [RULE3] [RULE13] [RULE20]
  assign sw_stop  = run_ok && wr_en && (waddr_q == ADDR_W'(`OFS_START))
                 && !wbyte_q[`START_FLAG_BIT] && flag_q; // [RULE18]

  // Edge taken from the second and third stages; first stage feeds only the second
  assign trig_start = run_ok && pfun_q && mode_q[`MODE_TRIG_BIT] && !flag_q && !sw_start
                   && (edge_q ? (trig_sync_q[1] && !trig_sync_q[2])
                              : (!trig_sync_q[1] && trig_sync_q[2])); // [RULE7] [RULE8]

  assign period     = mode_q[`MODE_SPEED_BIT] ? `PERIOD_FAST : `PERIOD_SLOW; // [RULE17]
  assign sample_len = period - `APPROX_CYCLES;
  // A stop in the last cycle wins: no result, no request
  assign done       = run_ok && (st_q != ST_IDLE) && (cnt_q == period - 6'd1)
                   && !sw_stop; // [RULE18]

  // Trial bit kept when input is at or above the trial code
  always_comb begin
    sar_dec = sar_q;
    if (!comp_sync_q[1]) begin
      sar_dec[bit_q] = 1'b0; // [RULE2]
    end
    if (bit_q != 4'd0) begin
      sar_dec[bit_q - 4'd1] = 1'b1; // [RULE2]
    end
  end

  // Bus next state
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    waddr_d   = waddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    mapped_r  = 1'b1;
    rbyte     = 8'h00;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];
      wlane_d  = s_axi_wstrb[0];
    end
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = ok_addr ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    case (s_axi_araddr)
      ADDR_W'(`OFS_MODE):      rbyte = {mode_q[7:6], 2'b11, mode_q[3:0]};
      ADDR_W'(`OFS_START):     rbyte = {flag_q, 7'h7F};
      ADDR_W'(`OFS_RES_HIGH):  rbyte = res_q[9:2];             // [RULE16]
      ADDR_W'(`OFS_RES_LOW):   rbyte = {res_q[1:0], 6'h00};    // [RULE16]
      ADDR_W'(`OFS_CLK_STOP):  rbyte = {3'b111, stby_q, 4'hF};
      ADDR_W'(`OFS_IRQ_REQ):   rbyte = 8'(req_q) << `IRQ_BIT;
      ADDR_W'(`OFS_IRQ_EN):    rbyte = 8'(ien_q) << `IRQ_BIT;
      ADDR_W'(`OFS_PORT_MODE): rbyte = 8'(pfun_q) << `PIN_FUNC_BIT;
      ADDR_W'(`OFS_EDGE_SEL):  rbyte = 8'(edge_q) << `EDGE_SEL_BIT;
      default:                 mapped_r = 1'b0;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, rbyte};
      rresp_d  = mapped_r ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      waddr_q   <= waddr_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Converter next state
  always_comb begin
    mode_d      = mode_q;
    flag_d      = flag_q;
    stby_d      = stby_q;
    req_d       = req_q;
    ien_d       = ien_q;
    pfun_d      = pfun_q;
    edge_d      = edge_q;
    st_d        = st_q;
    cnt_d       = cnt_q;
    step_d      = step_q;
    bit_d       = bit_q;
    sar_d       = sar_q;
    trig_sync_d = {trig_sync_q[1:0], external_trigger_pin};
    comp_sync_d = {comp_sync_q[0], comparator_in};
    if (wr_en && waddr_q == ADDR_W'(`OFS_CLK_STOP)) begin
      stby_d = wbyte_q[`STBY_BIT]; // [RULE1]
    end
    if (run_ok && wr_en) begin // [RULE20] [RULE10]
      case (waddr_q)
        ADDR_W'(`OFS_MODE):      mode_d = {wbyte_q[7:6], 2'b11, wbyte_q[3:0]};
        ADDR_W'(`OFS_IRQ_REQ):   req_d  = req_q && wbyte_q[`IRQ_BIT];
        ADDR_W'(`OFS_IRQ_EN):    ien_d  = wbyte_q[`IRQ_BIT];
        ADDR_W'(`OFS_PORT_MODE): pfun_d = wbyte_q[`PIN_FUNC_BIT];
        ADDR_W'(`OFS_EDGE_SEL):  edge_d = wbyte_q[`EDGE_SEL_BIT];
        default:                 mode_d = mode_q;
      endcase
    end
    if (sw_start || trig_start) begin
      flag_d = 1'b1; // [RULE3] [RULE8] [RULE13]
      st_d   = ST_SAMPLE;
      cnt_d  = 6'd0;
      step_d = 2'd0;
      bit_d  = 4'd9;
      sar_d  = 10'h200;
    end else if (sw_stop) begin
      flag_d = 1'b0; // [RULE18]
      st_d   = ST_IDLE;
    end else if (run_ok && st_q != ST_IDLE) begin
      cnt_d = cnt_q + 6'd1;
      if (st_q == ST_SAMPLE && cnt_q == sample_len - 6'd1) begin
        st_d = ST_APPROX;
      end
      if (st_q == ST_APPROX) begin
        step_d = step_q + 2'd1;
        if (step_q == `STEP_CYCLES - 2'd1) begin
          step_d = 2'd0;
          sar_d  = sar_dec; // [RULE2]
          bit_d  = bit_q - 4'd1;
        end
      end
      if (done) begin
        flag_d = 1'b0; // [RULE11] [RULE3]
        req_d  = 1'b1; // Set beats a same-cycle clear [RULE4] [RULE11]
        st_d   = ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q      <= `MODE_RESET; // [RULE9]
      flag_q      <= 1'b0;        // [RULE9]
      stby_q      <= 1'b1;        // [RULE1]
      req_q       <= 1'b0;
      ien_q       <= 1'b0;
      pfun_q      <= 1'b0;
      edge_q      <= 1'b0;
      st_q        <= ST_IDLE;
      cnt_q       <= 6'd0;
      step_q      <= 2'd0;
      bit_q       <= 4'd9;
      sar_q       <= 10'h000;
      trig_sync_q <= 3'b111;
      comp_sync_q <= 2'b00;
    end else begin
      mode_q      <= mode_d;
      flag_q      <= flag_d;
      stby_q      <= stby_d;
      req_q       <= req_d;
      ien_q       <= ien_d;
      pfun_q      <= pfun_d;
      edge_q      <= edge_d;
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      step_q      <= step_d;
      bit_q       <= bit_d;
      sar_q       <= sar_d;
      trig_sync_q <= trig_sync_d;
      comp_sync_q <= comp_sync_d;
    end
  end

  // Result kept across reset, so no reset branch; undefined only at power-up
  always_comb begin
    res_d = res_q;
    if (done) begin
      res_d = sar_dec; // [RULE11] [RULE16]
    end
  end

  always_ff @(posedge clk_sys) begin
    res_q <= res_d; // [RULE9]
  end

  assign dac_code             = sar_q;
  assign chan_bits            = chan_decode(mode_q[3:0]); // [RULE19]
  assign analog_channel_sel   = chan_bits[2:0];
  assign analog_channel_valid = chan_bits[3];
  assign sample_hold          = (st_q == ST_SAMPLE);
  assign conversion_end_irq   = req_q && ien_q; // [RULE5]

  // Helper: unheld cycles since the last start, saturating at 127
  logic [6:0] run_len_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run_len_q <= 7'd0;
    end else if (sw_start || trig_start) begin
      run_len_q <= 7'd1;
    end else if (run_ok && run_len_q != 7'h7F) begin
      run_len_q <= run_len_q + 7'd1;
    end
  end

  sequence s_finish;
    !flag_q && req_q && st_q == ST_IDLE;
  endsequence

  a_start_sets_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
    sw_start |=> flag_q && st_q == ST_SAMPLE) else $error("start did not set flag"); // [RULE3]
  a_done_finishes: assert property (@(posedge clk_sys) disable iff (!resetn)
    done |=> s_finish) else $error("completion sequence wrong"); // [RULE4] [RULE11]
  a_irq_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
    conversion_end_irq |-> ien_q && req_q) else $error("irq without enable"); // [RULE5]
  a_period_len: assert property (@(posedge clk_sys) disable iff (!resetn)
    done |-> run_len_q == {1'b0, period}) else $error("conversion length wrong"); // [RULE17]
  a_stop_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    sw_stop |=> !flag_q && st_q == ST_IDLE && $stable(req_q)) else $error("stop failed"); // [RULE18]
  a_standby_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !run_ok |=> $stable(mode_q) && $stable(flag_q) && $stable(res_q))
    else $error("register changed while held"); // [RULE20] [RULE10]
  a_trig_enable: assert property (@(posedge clk_sys) disable iff (!resetn)
    trig_start |-> pfun_q && mode_q[`MODE_TRIG_BIT]) else $error("trigger not enabled"); // [RULE7]
  a_chan_one: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_q[3:0] == 4'h5 |-> analog_channel_valid && analog_channel_sel == 3'd1)
    else $error("channel one not routed"); // [RULE12]

endmodule
`default_nettype wire

// ---- design/sar_adc_pkg.sv ----
// Types shared by the converter control
// Assumes sar_adc_cfg.svh is on the include path
package sar_adc_pkg;
  `include "sar_adc_cfg.svh"

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_APPROX = 2'b11
  } conv_state_e;

  typedef logic [1:0] axi_resp_t;
  localparam axi_resp_t RESP_OKAY   = 2'b00;
  localparam axi_resp_t RESP_SLVERR = 2'b10;
endpackage

// ---- dv/sar_adc_analog_model.sv ----
// Far-side model: eight analog levels sharing one comparator
// Assumes levels are packed ten bits per channel, channel 0 in the lowest bits
`timescale 1ns/1ps
`default_nettype none

module sar_adc_analog_model (
  input  wire logic        clk_sys,
  input  wire logic [79:0] levels,
  input  wire logic [9:0]  dac_code,
  input  wire logic [2:0]  analog_channel_sel,
  input  wire logic        analog_channel_valid,
  output logic             comparator_in
);
  logic       noise_q = 1'b0;
  logic [9:0] level;

  // Unrouted comparator floats, so toggle rather than keep a stale answer
  always_ff @(posedge clk_sys) begin
    noise_q <= ~noise_q;
  end

  assign level = levels[analog_channel_sel*10 +: 10];
  // Ideal comparator: high while the routed level is at or above the trial code
  assign comparator_in = analog_channel_valid ? (level >= dac_code) : noise_q;
endmodule
`default_nettype wire

// ---- dv/test_sar_adc_control.sv ----
// Self-checking bench: bus tasks, random levels, corner cases for the converter control
// Assumes the design files and the analog model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_cfg.svh"
`define CHK(g, e, m) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] %0t %s: got %0h exp %0h", $time, m, g, e); \
  end \
end

module test_sar_adc_control import sar_adc_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        low_power_hold = 1'b0;
  logic        external_trigger_pin = 1'b1;
  logic [79:0] levels = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp;
  logic [31:0] s_axi_rdata, rdat;
  logic        comparator_in, analog_channel_valid, sample_hold, conversion_end_irq;
  logic [9:0]  dac_code, v, e;
  logic [2:0]  analog_channel_sel;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc;

  sar_adc_control u_sar_adc_control (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_power_hold, .external_trigger_pin,
    .comparator_in, .dac_code, .analog_channel_sel, .analog_channel_valid, .sample_hold,
    .conversion_end_irq);

  sar_adc_analog_model u_sar_adc_analog_model (.clk_sys, .levels, .dac_code,
    .analog_channel_sel, .analog_channel_valid, .comparator_in);

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic hang(input string m);
    error_cnt++;
    $display("[FAIL] %0t %s timed out", $time, m);
    report_and_stop();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Handshakes judged at the falling edge, acted on just after the rising one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic       ta, tw, dn;
    logic [1:0] br;
    int         n;
    dn = 1'b0;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!dn) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      dn = s_axi_bvalid;
      br = s_axi_bresp;
      n++;
      if (n > 50) hang("write");
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK(br, RESP_OKAY, "bresp")
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, dn;
    int   n;
    dn = 1'b0;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid & s_axi_arready;
      dn = s_axi_rvalid;
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      n++;
      if (n > 50) hang("read");
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] x, input string m);
    rd(a);
    `CHK(rdat, {24'h0, x}, m)
    `CHK(rrsp, RESP_OKAY, m)
  endtask

  task automatic wait_irq();
    cyc = 0;
    while (conversion_end_irq !== 1'b1) begin
      @(negedge clk_sys);
      cyc++;
      if (cyc > 150) hang("end of conversion");
    end
    @(posedge clk_sys);
  endtask

  function automatic logic [9:0] exp_sar(input logic [9:0] lv);
    logic [9:0] c;
    c = '0;
    for (int b = 9; b >= 0; b--) begin
      if (lv >= (c | (10'h1 << b)))
        c = c | (10'h1 << b);
    end
    return c;
  endfunction

  // Software start on channel one, timed from the bus response to the interrupt
  task automatic conv(input logic sp, input logic [9:0] lv);
    logic [9:0] x;
    int         p;
    x = exp_sar(lv);
    p = sp ? 31 : 62;
    levels[19:10] <= lv;
    wr(`OFS_MODE, {sp, 7'h35});
    wr(`OFS_START, 8'h80);
    if (!sp) `CHK(sample_hold, 1'b1, "sampling")
    wait_irq();
    `CHK(sample_hold, 1'b0, "idle after end")
    `CHK(cyc >= p - 3 && cyc <= p, 1'b1, "period")
    rc(`OFS_START, 8'h7F, "flag clear");
    rd(`OFS_IRQ_REQ);
    `CHK(rdat[3], 1'b1, "end request")
    rc(`OFS_RES_HIGH, x[9:2], "result high");
    rc(`OFS_RES_LOW, {x[1:0], 6'h00}, "result low");
    wr(`OFS_IRQ_REQ, 8'h00);
    `CHK(conversion_end_irq, 1'b0, "request cleared")
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    hang("run");
  end

  initial begin
    void'($urandom(32'h0977));
    idle(12);
    resetn <= 1'b1;
    rc(`OFS_MODE, 8'h30, "mode reset");
    rc(`OFS_START, 8'h7F, "start reset");
    rc(`OFS_CLK_STOP, 8'hFF, "standby bit reset");
    `CHK(analog_channel_valid, 1'b0, "no channel")
    rd(8'h24);
    `CHK(rrsp, RESP_SLVERR, "unmapped resp")
    `CHK(rdat, 32'h0, "unmapped data")
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      wr(`OFS_MODE, {4'h3, c[3:0]});
      `CHK(analog_channel_valid, c[3:2] inside {2'b01, 2'b10}, "valid")
      if (c[3:2] inside {2'b01, 2'b10}) `CHK(analog_channel_sel, {c[3], c[1:0]}, "sel")
      rc(`OFS_MODE, {4'h3, c[3:0]}, "mode readback");
    end
    $display("test channels done");
    wr(`OFS_IRQ_EN, 8'h08);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($urandom);
      conv(i[0], v);
    end
    $display("test conversions done");
    wr(`OFS_IRQ_EN, 8'h00);
    wr(`OFS_START, 8'h80);
    idle(70);
    `CHK(conversion_end_irq, 1'b0, "masked")
    rd(`OFS_IRQ_REQ);
    `CHK(rdat[3], 1'b1, "request while masked")
    wr(`OFS_IRQ_EN, 8'h08);
    `CHK(conversion_end_irq, 1'b1, "unmasked")
    wr(`OFS_IRQ_REQ, 8'h00);
    wr(`OFS_START, 8'h80);
    rc(`OFS_START, 8'hFF, "flag busy");
    wr(`OFS_START, 8'h00);
    idle(80);
    rc(`OFS_START, 8'h7F, "stopped");
    `CHK(conversion_end_irq, 1'b0, "no end after stop")
    $display("test mask and stop done");
    for (int k = 0; k < 2; k++) begin
      wr(`OFS_PORT_MODE, {3'h0, k[0], 4'h0});
      wr(`OFS_MODE, k[0] ? 8'h35 : 8'h75);
      external_trigger_pin <= 1'b0;
      idle(8);
      external_trigger_pin <= 1'b1;
      rc(`OFS_START, 8'h7F, "trigger refused");
    end
    for (int ed = 0; ed < 2; ed++) begin
      external_trigger_pin <= ed[0];
      wr(`OFS_EDGE_SEL, {3'h0, ed[0], 4'h0});
      wr(`OFS_MODE, 8'h75);
      external_trigger_pin <= ~ed[0];
      idle(6);
      rc(`OFS_START, 8'h7F, "wrong edge");
      external_trigger_pin <= ed[0];
      wait_irq();
      wr(`OFS_IRQ_REQ, 8'h00);
    end
    $display("test trigger done");
    wr(`OFS_MODE, 8'h35);
    wr(`OFS_CLK_STOP, 8'hEF);
    rc(`OFS_CLK_STOP, 8'hEF, "standby set");
    wr(`OFS_START, 8'h80);
    wr(`OFS_MODE, 8'hB5);
    rc(`OFS_START, 8'h7F, "start in standby");
    rc(`OFS_MODE, 8'h35, "mode in standby");
    wr(`OFS_CLK_STOP, 8'hFF);
    idle(10);
    conv(1'b1, 10'h2AA);
    $display("test standby done");
    // Bus stays quiet under the hold: the freeze covers the converter only, not the slave
    wr(`OFS_START, 8'h80);
    low_power_hold <= 1'b1;
    idle(100);
    `CHK(conversion_end_irq, 1'b0, "held")
    low_power_hold <= 1'b0;
    wait_irq();
    e = exp_sar(10'h2AA);
    resetn <= 1'b0;
    idle(3);
    resetn <= 1'b1;
    rc(`OFS_RES_HIGH, e[9:2], "result kept");
    rc(`OFS_RES_LOW, {e[1:0], 6'h00}, "low kept");
    rc(`OFS_MODE, 8'h30, "mode after reset");
    $display("test hold and reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
